// ---- hw/cfs_pkg.sv ----
// Purpose: shared constants and helpers for the clock fanout select/enable block
// Assumes: one 20 MHz core clock; input clocks arrive as sampled levels
// Notes: Function list below
// Function
// R01 - exactly one of the two input clocks reaches the outputs, chosen by the source-select level.
// R02 - an undriven source-select, output-clear or output-enable input counts as high.
// R03 - the switch to a newly selected clock waits for a safe point, so its latency varies.
// R04 - with no input clock or too little amplitude the outputs hold their present state.
// R05 - a floating, static or tiny input clock leaves the outputs at a steady level.
// R06 - only a missing or collapsed clock triggers the hold, not a slowly degrading one.
// R07 - a low output-clear forces true outputs low and complement outputs high at once.
// R08 - the cleared state lasts while output-clear is low and ends only once it is high.
// R09 - output-enable is sampled on input clock edges; high passes the clock, low disables.
// R10 - while disabled the true outputs are low and the complement outputs high.
// R11 - an enable change reaches the outputs after 2 to 6 input clock cycles via a flop chain.
// R12 - enabling and disabling happen on clock boundaries with no shortened pulse.
// R13 - a low output-clear overrides both the enable and the fail-safe hold.
package cfs_pkg;
	localparam int NUM_OUT = 15;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam int CTRL_WDOG_BIT = 0;
	localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0001;
	localparam int ST_SEL_BIT = 0;
	localparam int ST_HOLD_BIT = 1;
	localparam int ST_EN_BIT = 2;
	localparam int ST_CLR_BIT = 3;
	localparam int ST_GATE_BIT = 4;
	localparam int ST_SWITCH_BIT = 5;
	localparam int CLK_PERIOD_NS = 50;
	localparam int LOSS_TIME_NS = 1000;
	localparam int LOSS_CYC = (LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOSS_W = 6;
	localparam int EN_STAGES = 3;
	localparam int EN_MIN_CYC = 2;
	localparam int EN_MAX_CYC = 6;

	typedef enum logic [0:0] {
		SEL_RUN,
		SEL_SWITCH
	} cfs_sel_e;

	// an open pin is pulled up
	function automatic logic pin_level(input logic drv, input logic lvl);
		return drv ? lvl : 1'b1;
	endfunction
endpackage

// ---- hw/cfs_clk_if.sv ----
// Purpose: carrier between the fanout core and its helper modules
// Assumes: all signals in the core clock domain
// Notes: rise and fall are one-cycle pulses of the selected input clock
`timescale 1ns/1ps
interface cfs_clk_if;
	logic clk_lvl;
	logic rise;
	logic fall;
	logic amp_ok;
	logic hold;
	logic en_pin;
	logic en_sync;
	modport core (output clk_lvl, rise, fall, amp_ok, en_pin, input hold, en_sync);
	modport loss (input rise, fall, amp_ok, output hold);
	modport chain (input rise, en_pin, output en_sync);
endinterface

// ---- hw/cfs_loss_detect.sv ----
// Purpose: fail-safe hold detector for the selected input clock
// Assumes: edges of the selected clock arrive as pulses
// Notes: window length is a package constant
`timescale 1ns/1ps
module cfs_loss_detect (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic wdog_en_i,
	cfs_clk_if.loss ck
);
	import cfs_pkg::*;
	localparam logic [LOSS_W-1:0] LOSS_LIM = LOSS_W'(LOSS_CYC);
	logic [LOSS_W-1:0] cnt_q;
	logic hold_q;
	wire edge_seen = ck.rise | ck.fall;
	wire cnt_full = (cnt_q == LOSS_LIM);
	// a toggling clock, however distorted, keeps the counter cleared
	wire hold_d = (wdog_en_i & cnt_full) | ~ck.amp_ok; // see R04 see R06

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			cnt_q <= '0;
			hold_q <= 1'b0;
		end else begin
			cnt_q <= edge_seen ? '0 : (cnt_full ? cnt_q : cnt_q + 1'b1); // see R05
			hold_q <= hold_d;
		end
	end
	assign ck.hold = hold_q;

	a_loss_sets_hold: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see R05
		(wdog_en_i && cnt_full) |=> ck.hold)
		else $error("hold not raised after clock loss");
	a_live_clock_free: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see R06
		(ck.rise && ck.amp_ok) ##1 ck.amp_ok |-> ##1 !ck.hold)
		else $error("hold raised with live clock");
endmodule // cfs_loss_detect

// ---- hw/cfs_en_chain.sv ----
// Purpose: enable resynchroniser stepped by the selected input clock
// Assumes: rise pulses mark input clock edges
// Notes: chain length sets the enable latency
`timescale 1ns/1ps
module cfs_en_chain (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic clear_i,
	cfs_clk_if.chain ck
);
	import cfs_pkg::*;
	logic [EN_STAGES-1:0] chain_q;

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || clear_i) begin
			chain_q <= '0;
		end else if (ck.rise) begin
			chain_q <= {chain_q[EN_STAGES-2:0], ck.en_pin}; // see R09 see R11
		end
	end
	assign ck.en_sync = chain_q[EN_STAGES-1];
endmodule // cfs_en_chain

// ---- hw/cfs_fanout.sv ----
// Purpose: source select, fail-safe hold, output clear and enable for a clock fanout
// Assumes: input clocks and pins are synchronous samples of the core clock
// Notes: registers at REG_CTRL and REG_STATUS over a plain strobe port
`timescale 1ns/1ps
module cfs_fanout (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic clk_a_i,
	input wire logic clk_b_i,
	input wire logic amp_ok_a_i,
	input wire logic amp_ok_b_i,
	input wire logic src_sel_i,
	input wire logic src_sel_drv_i,
	input wire logic output_clear_n_i,
	input wire logic output_clear_n_drv_i,
	input wire logic out_en_i,
	input wire logic out_en_drv_i,
	input wire logic [cfs_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [cfs_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [cfs_pkg::DATA_W-1:0] reg_rdata_o,
	output logic [cfs_pkg::NUM_OUT-1:0] q_o,
	output logic [cfs_pkg::NUM_OUT-1:0] qn_o
);
	import cfs_pkg::*;

	cfs_clk_if ck ();

	// pin levels with pull-up default
	wire sel_lvl = pin_level(src_sel_drv_i, src_sel_i); // see R02
	wire clear_n_lvl = pin_level(output_clear_n_drv_i, output_clear_n_i); // see R02
	wire en_lvl = pin_level(out_en_drv_i, out_en_i); // see R02

	logic a_q;
	logic b_q;
	logic a_prev_q;
	logic b_prev_q;
	logic cur_sel_q;
	cfs_sel_e st_q;
	cfs_sel_e st_d;
	logic gate_q;
	logic out_q;
	logic [DATA_W-1:0] ctrl_q;
	logic [DATA_W-1:0] rdata_q;

	// selected source, by current choice
	wire sel_now = cur_sel_q ? b_q : a_q; // see R01
	wire sel_prev = cur_sel_q ? b_prev_q : a_prev_q;
	wire both_low = ~a_q & ~b_q;
	wire want_switch = (sel_lvl != cur_sel_q);
	// wait for both clocks low so no sliver of either leaks out
	wire do_switch = (st_q == SEL_SWITCH) & both_low; // see R03
	wire pass_lvl = gate_q & ck.clk_lvl;
	wire gate_upd = ~ck.clk_lvl; // see R12
	wire wdog_en = ctrl_q[CTRL_WDOG_BIT];

	assign ck.clk_lvl = sel_now;
	assign ck.rise = sel_now & ~sel_prev;
	assign ck.fall = ~sel_now & sel_prev;
	assign ck.amp_ok = cur_sel_q ? amp_ok_b_i : amp_ok_a_i;
	assign ck.en_pin = en_lvl;

	cfs_loss_detect u_loss (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.wdog_en_i(wdog_en),
		.ck(ck.loss)
	);

	cfs_en_chain u_chain (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.clear_i(~clear_n_lvl),
		.ck(ck.chain)
	);

	always_comb begin
		st_d = st_q;
		case (st_q)
			SEL_RUN: begin
				if (want_switch) begin
					st_d = SEL_SWITCH;
				end
			end
			SEL_SWITCH: begin
				if (!want_switch || both_low) begin
					st_d = SEL_RUN;
				end
			end
			default: begin
				st_d = SEL_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
			a_prev_q <= 1'b0;
			b_prev_q <= 1'b0;
		end else begin
			a_q <= clk_a_i;
			b_q <= clk_b_i;
			a_prev_q <= a_q;
			b_prev_q <= b_q;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			st_q <= SEL_RUN;
			cur_sel_q <= 1'b1;
		end else begin
			st_q <= st_d;
			if (do_switch && want_switch) begin
				cur_sel_q <= sel_lvl; // see R01
			end
		end
	end

	// gate follows the enable only while the clock is low, so pulses are whole; clear drops it at any level
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || !clear_n_lvl) begin
			gate_q <= 1'b0; // see R13
		end else if (gate_upd) begin
			gate_q <= ck.en_sync; // see R09 see R12
		end
	end

	// hold freezes the last output level; clear must win so release starts low
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || !clear_n_lvl) begin
			out_q <= 1'b0; // see R13
		end else if (!ck.hold) begin
			out_q <= pass_lvl; // see R04 see R10
		end
	end

	// clear acts without a clock edge: gated after the flop
	assign q_o = {NUM_OUT{out_q & clear_n_lvl}}; // see R07 see R08 see R13
	assign qn_o = ~q_o; // see R07

	// register port
	wire wr_ctrl = reg_we_i & (reg_addr_i == REG_CTRL);
	wire [DATA_W-1:0] status_w = DATA_W'({st_q == SEL_SWITCH, gate_q, ~clear_n_lvl,
		ck.en_sync, ck.hold, cur_sel_q});
	wire [DATA_W-1:0] rd_mux = (reg_addr_i == REG_CTRL) ? ctrl_q :
		(reg_addr_i == REG_STATUS) ? status_w : '0;

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			ctrl_q <= CTRL_RST;
			rdata_q <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata_i & CTRL_RST;
			end
			rdata_q <= reg_re_i ? rd_mux : '0;
		end
	end
	assign reg_rdata_o = rdata_q;

	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	logic [3:0] en_wait_q;
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || gate_q == en_lvl || !clear_n_lvl || ck.hold || $changed(en_lvl)) begin
			en_wait_q <= '0;
		end else if (ck.rise && en_wait_q != 4'hf) begin
			en_wait_q <= en_wait_q + 4'h1;
		end
	end

	sequence s_clear_release;
		!clear_n_lvl ##1 clear_n_lvl;
	endsequence

	sequence s_switch_done;
		(st_q == SEL_SWITCH && want_switch) ##1 $changed(cur_sel_q);
	endsequence

	a_clear_forces: assert property (!clear_n_lvl |-> q_o == '0 && qn_o == '1) // see R07
		else $error("clear did not force outputs");
	a_clear_release: assert property (s_clear_release |-> q_o == '0 && !gate_q) // see R08
		else $error("outputs left cleared state early");
	a_clear_priority: assert property ((!clear_n_lvl && ck.hold) |=> !gate_q) // see R13
		else $error("clear lost to hold or enable");
	a_disabled_low: assert property ((!gate_q && clear_n_lvl && !ck.hold) |=> q_o == '0) // see R10
		else $error("disabled outputs not low");
	a_hold_freezes: assert property (ck.hold |=> $stable(out_q)) // see R04
		else $error("outputs moved during hold");
	a_gate_boundary: assert property ($changed(gate_q) && clear_n_lvl |-> !$past(ck.clk_lvl)) // see R12
		else $error("enable changed mid pulse");
	a_switch_safe: assert property (s_switch_done |-> $past(both_low)) // see R01 see R03
		else $error("source switched while a clock was high");
	a_en_latency: assert property (en_wait_q <= 4'(EN_MAX_CYC)) // see R11
		else $error("enable took too many input cycles");
	a_default_high: assert property (!out_en_drv_i |-> ck.en_pin) // see R02
		else $error("open enable pin not high");
endmodule // cfs_fanout

// ---- bench/cfs_src_model.sv ----
// Purpose: two input clock sources feeding the fanout block
// Assumes: sources toggle slower than half the core clock
// Notes: source a can be stopped or weakened on request
`timescale 1ns/1ps
module cfs_src_model (
	input wire logic core_clk_i,
	input wire logic stop_a_i,
	input wire logic weak_a_i,
	output logic clk_a_o,
	output logic clk_b_o,
	output logic amp_ok_a_o,
	output logic amp_ok_b_o
);
	logic [3:0] cnt_a_q = 4'h0;
	logic [3:0] cnt_b_q = 4'h0;
	initial begin
		clk_a_o = 1'b0;
		clk_b_o = 1'b0;
	end
	// half periods differ (4 and 6) so the bench can tell the sources apart
	always @(posedge core_clk_i) begin
		cnt_a_q <= (cnt_a_q == 4'h3) ? 4'h0 : cnt_a_q + 4'h1;
		cnt_b_q <= (cnt_b_q == 4'h5) ? 4'h0 : cnt_b_q + 4'h1;
		if (cnt_a_q == 4'h3 && !stop_a_i) begin
			clk_a_o <= ~clk_a_o;
		end
		if (cnt_b_q == 4'h5) begin
			clk_b_o <= ~clk_b_o;
		end
		amp_ok_a_o <= ~weak_a_i;
		amp_ok_b_o <= 1'b1;
	end
endmodule // cfs_src_model

// ---- bench/tb_top.sv ----
// Purpose: self-checking bench for the clock fanout select/enable block
// Assumes: source a half period 4 core cycles, source b 6
// Notes: register reads are checked from a queue by a monitor
`timescale 1ns/1ps
module tb_top;
	import cfs_pkg::*;
	logic core_clk_i = 0, nrst_i = 0, stop_a = 0, weak_a = 0, rd_pend = 0, chk_w = 0;
	logic clk_a, clk_b, ok_a, ok_b, sel = 1, sel_drv = 0, clr_n = 1, clr_drv = 0;
	logic en = 1, en_drv = 0, we = 0, re = 0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0, rdata, e, m;
	logic [NUM_OUT-1:0] q, qn, qf;
	logic [DATA_W-1:0] exp_q[$], msk_q[$];
	int n_mismatch = 0, num_checks = 0, run = 0;
	int seed = 32'haa1910de;
	initial forever #25 core_clk_i = ~core_clk_i;
	cfs_src_model src_u (.core_clk_i(core_clk_i), .stop_a_i(stop_a), .weak_a_i(weak_a),
		.clk_a_o(clk_a), .clk_b_o(clk_b), .amp_ok_a_o(ok_a), .amp_ok_b_o(ok_b));
	cfs_fanout dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .clk_a_i(clk_a), .clk_b_i(clk_b),
		.amp_ok_a_i(ok_a), .amp_ok_b_i(ok_b), .src_sel_i(sel), .src_sel_drv_i(sel_drv),
		.output_clear_n_i(clr_n), .output_clear_n_drv_i(clr_drv), .out_en_i(en),
		.out_en_drv_i(en_drv), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we),
		.reg_re_i(re), .reg_rdata_o(rdata), .q_o(q), .qn_o(qn));
	task automatic chk(input string nm, input logic [31:0] ev, input logic [31:0] gv);
		num_checks++;
		if (gv !== ev) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, ev, gv);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk_i);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk_i);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ev,
		input logic [DATA_W-1:0] mk);
		@(posedge core_clk_i);
		re <= 1'b1;
		addr <= a;
		exp_q.push_back(ev);
		msk_q.push_back(mk);
		@(posedge core_clk_i);
		re <= 1'b0;
	endtask
	// counts output changes over n cycles; move says whether any are wanted
	task automatic tog(input string nm, input int n, input bit move);
		int t;
		logic p;
		t = 0;
		@(negedge core_clk_i);
		p = q[0];
		repeat (n) begin
			@(negedge core_clk_i);
			if (q[0] !== p) t++;
			p = q[0];
		end
		chk(nm, {31'h0, move}, {31'h0, t > 0});
	endtask
	always @(posedge core_clk_i) rd_pend <= re;
	// read data stand one cycle only, so they are taken mid-cycle
	always @(negedge core_clk_i) begin
		if (rd_pend) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			chk("rdata", e, rdata & m);
		end
		if (nrst_i) chk("qn", {17'h0, ~q}, {17'h0, qn});
		run = q[0] ? run + 1 : run;
		if (!q[0] && run != 0) begin
			if (chk_w) chk("high run", 32'd4, run);
			run = 0;
		end
	end
	initial begin
		cyc(5000);
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		cyc(6);
		nrst_i <= 1'b1;
		@(negedge core_clk_i);
		chk("q reset", 0, q);
		rd(REG_CTRL, CTRL_RST, '1);
		rd(8'h08, 0, '1);
		wr(REG_CTRL, $random(seed) & 32'hffff_fffe);
		rd(REG_CTRL, 0, '1);
		wr(REG_CTRL, $random(seed) | 32'h1);
		rd(REG_CTRL, 1, '1);
		cyc(60);
		rd(REG_STATUS, 32'h5, 32'hd);
		tog("open pins run", 30, 1);
		sel_drv <= 1'b1;
		sel <= 1'b0;
		cyc(60);
		rd(REG_STATUS, 32'h0, 32'h21);
		chk_w = 1;
		tog("source a", 40, 1);
		en_drv <= 1'b1;
		en <= 1'b0;
		tog("early disable", 12, 1);
		cyc(36);
		tog("disabled", 16, 0);
		chk("q disabled", 0, q);
		en <= 1'b1;
		cyc(48);
		tog("enabled", 16, 1);
		chk_w = 0;
		@(posedge core_clk_i);
		clr_drv <= 1'b1;
		clr_n <= 1'b0;
		weak_a <= 1'b1;
		#1;
		chk("q clear", 0, q);
		chk("qn clear", {NUM_OUT{1'b1}}, qn);
		tog("cleared", 20, 0);
		chk("q clear held", 0, q);
		weak_a <= 1'b0;
		clr_n <= 1'b1;
		cyc(60);
		tog("after clear", 20, 1);
		stop_a <= 1'b1;
		cyc(30);
		qf = q;
		tog("stopped", 20, 0);
		chk("frozen", qf, q);
		rd(REG_STATUS, 32'h2, 32'h2);
		stop_a <= 1'b0;
		cyc(40);
		tog("restart", 20, 1);
		weak_a <= 1'b1;
		cyc(3);
		tog("weak", 20, 0);
		weak_a <= 1'b0;
		cyc(4);
		report_and_stop();
	end
endmodule // tb_top
